/* hdl/aqstc_ctrl.v */
// scan mode and trigger control for one command queue
`timescale 1ns/100ps
`include "aqstc_defs.vh"

// What this block does
// - single scan stops after end-of-queue command
// - continuous scan rearms itself after end-of-queue
// - disable accepted anytime; disabled queue never triggers
// - disable: idle now, or finish on-chip transfer
// - disable aborts serial unless 26th bit gone
// - disable keeps contents; invalidate bit clears them
// - disable keeps counter; writing zero clears it
// - disable negates single-scan status; same-write enable works
// - disable resets detection; fresh edge needed after
// - fill requests continue until fill enable cleared
// - software mode triggers on single-scan status
// - single-scan edge and level ignored without single-scan status
// - only hardware or a disable clears single-scan status
// - enable while status set changes nothing
// - pause bit ignored in software and level
// - end-of-queue clears status, stops software/edge modes
// - edge pause stops, keeps status, edge resumes
// - edge while triggered sets trigger overrun
// - gate polarity; status set with gate open triggers
// - gate close stops now or after transfer
// - gate close and reopen within transfer: overrun
module aqstc_ctrl #(
  parameter TCW = 11
) (
  input  wire           ref_clk_i,
  input  wire           arst_n_i,
  input  wire [7:0]     addr_i,
  input  wire [31:0]    wdata_i,
  input  wire           wr_i,
  input  wire           rd_i,
  output reg  [31:0]    rdata_o,
  input  wire           trig_i,
  input  wire           cmd_start_i,
  input  wire           cmd_ext_i,
  input  wire           cmd_done_i,
  input  wire           cmd_eoq_i,
  input  wire           cmd_pause_i,
  input  wire           ser_bit26_i,
  input  wire           fill_flag_i,
  output wire [1:0]     queue_status_o,
  output wire           single_scan_status_o,
  output wire           xfer_enable_o,
  output wire           abort_o,
  output wire           invalidate_o,
  output wire           fill_req_o
);

  ////////////////////////////////////////////////////////////////////
  // state

  reg [3:0]     mode_ff;
  reg [1:0]     status_ff;
  reg           sss_ff;
  reg           pf_ff;
  reg           trigger_overrun_flag_ff;
  reg           eoqf_ff;
  // transfer counter, loaded by software
  reg [TCW-1:0] tc_ff;
  reg           fill_en_ff;
  reg           inflight_ff;
  reg           ext_ff;
  reg           dis_pend_ff;
  reg           gate_pend_ff;
  reg           xfer_en_ff;
  reg           abort_ff;
  reg           inval_ff;
  reg           fill_req_ff;

  // combinational next values, one per register except xfer_en_ff and fill_req_ff
  reg [3:0]     nxt_mode;
  reg [1:0]     nxt_status;
  reg           nxt_sss;
  reg           nxt_pf;
  reg           nxt_trigger_overrun_flag;
  reg           nxt_eoqf;
  reg [TCW-1:0] nxt_tc;
  reg           nxt_fill_en;
  reg           nxt_inflight;
  reg           nxt_ext;
  reg           nxt_dis_pend;
  reg           nxt_gate_pend;
  reg           nxt_abort;
  reg           nxt_inval;
  reg [31:0]    nxt_rdata;

  ////////////////////////////////////////////////////////////////////
  // mode decode and trigger detection

  // mode bit 3: continuous; bits 2:0: trigger kind
  wire [2:0] kind      = mode_ff[2:0];
  wire       is_dis    = (mode_ff == `AQSTC_MODE_DISABLED);
  wire       is_cs     = mode_ff[`AQSTC_MODE_CS_BIT];
  wire       is_sw     = (kind == `AQSTC_KIND_SW);
  wire       is_edge   = (kind == `AQSTC_KIND_RISE) | (kind == `AQSTC_KIND_FALL) |
                         (kind == `AQSTC_KIND_BOTH);
  wire       is_level  = (kind == `AQSTC_KIND_HIGH) | (kind == `AQSTC_KIND_LOW);
  wire       det_en    = ~is_dis & (is_cs | sss_ff);
  wire       edge_evt;
  wire       gate_open;

  // register bus decode; reads answer one cycle later
  wire wr_ctrl = wr_i & (addr_i == `AQSTC_OFF_CTRL);
  wire wr_stat = wr_i & (addr_i == `AQSTC_OFF_STAT);
  wire wr_tcnt = wr_i & (addr_i == `AQSTC_OFF_TCNT);
  wire [3:0] wr_mode = wdata_i[`AQSTC_CTRL_MODE_MSB:`AQSTC_CTRL_MODE_LSB];
  wire [TCW-1:0] tc_inc = tc_ff + {{(TCW-1){1'b0}}, 1'b1};

  // edges count only after detection has been enabled for a cycle
  aqstc_trig_detect u_det (
    .ref_clk_i   (ref_clk_i),
    .arst_n_i    (arst_n_i),
    .trig_i      (trig_i),
    .det_en_i    (det_en),
    .kind_i      (kind),
    .edge_o      (edge_evt),
    .gate_open_o (gate_open)
  );

  ////////////////////////////////////////////////////////////////////
  // next state

  always @* begin
    nxt_mode      = mode_ff;
    nxt_status    = status_ff;
    nxt_sss       = sss_ff;
    nxt_pf        = pf_ff;
    nxt_trigger_overrun_flag      = trigger_overrun_flag_ff;
    nxt_eoqf      = eoqf_ff;
    nxt_tc        = tc_ff;
    nxt_fill_en   = fill_en_ff;
    nxt_inflight  = inflight_ff;
    nxt_ext       = ext_ff;
    nxt_dis_pend  = dis_pend_ff;
    nxt_gate_pend = gate_pend_ff;
    nxt_abort     = 1'b0;
    nxt_inval     = 1'b0;

    // software writes; flag clears come first so hardware sets win
    if (wr_ctrl) begin
      if (wr_mode == `AQSTC_MODE_DISABLED)
        nxt_mode = `AQSTC_MODE_DISABLED;
      else if (is_dis && status_ff == `AQSTC_QS_IDLE)
        nxt_mode = wr_mode;
      nxt_inval   = wdata_i[`AQSTC_CTRL_INV_BIT];
      nxt_fill_en = wdata_i[`AQSTC_CTRL_FE_BIT];
      // set only; a set status stays set without overrun
      if (wdata_i[`AQSTC_CTRL_SSE_BIT] && nxt_mode != `AQSTC_MODE_DISABLED &&
          !nxt_mode[`AQSTC_MODE_CS_BIT])
        nxt_sss = 1'b1;
    end
    if (wr_stat) begin
      if (wdata_i[`AQSTC_STAT_PF_BIT])   nxt_pf   = 1'b0;
      if (wdata_i[`AQSTC_STAT_TRIGGER_OVERRUN_FLAG_BIT]) nxt_trigger_overrun_flag = 1'b0;
      if (wdata_i[`AQSTC_STAT_EOQF_BIT]) nxt_eoqf = 1'b0;
    end
    // counter load; a done in the same cycle wins
    if (wr_tcnt)
      nxt_tc = wdata_i[TCW-1:0];

    // transfer bookkeeping
    if (cmd_start_i) begin
      nxt_inflight = 1'b1;
      nxt_ext      = cmd_ext_i;
    end
    // a done with nothing in flight is ignored
    if (cmd_done_i && inflight_ff) begin
      nxt_inflight = 1'b0;
      nxt_tc       = tc_inc;
      if (cmd_eoq_i)
        nxt_eoqf = 1'b1;
    end

    // disable: finish or abort the transfer in flight
    if (dis_pend_ff || (!is_dis && nxt_mode == `AQSTC_MODE_DISABLED)) begin
      // leaving service: contents and counter are kept
      nxt_sss       = 1'b0;
      nxt_gate_pend = 1'b0;
      if (!inflight_ff || cmd_done_i) begin
        nxt_status   = `AQSTC_QS_IDLE;
        nxt_dis_pend = 1'b0;
      end else if (ext_ff && !ser_bit26_i) begin
        nxt_abort    = 1'b1;
        nxt_inflight = 1'b0;
        nxt_status   = `AQSTC_QS_IDLE;
        nxt_dis_pend = 1'b0;
      end else begin
        nxt_dis_pend = 1'b1;
      end
    end else if (is_dis) begin
      nxt_status = `AQSTC_QS_IDLE;
      if (nxt_mode == `AQSTC_MODE_DISABLED)
        nxt_sss = 1'b0;
    end else begin
      // normal service: idle, waiting and triggered
      case (status_ff)
        `AQSTC_QS_IDLE: begin
          // continuous software mode triggers at once
          if (is_cs && is_sw)
            nxt_status = `AQSTC_QS_TRIG;
          else if (is_cs || is_sw || sss_ff)
            nxt_status = `AQSTC_QS_WAIT;
        end
        `AQSTC_QS_WAIT: begin
          // software mode: single-scan status is the trigger
          if (is_sw && sss_ff)
            nxt_status = `AQSTC_QS_TRIG;
          else if (edge_evt || gate_open)
            nxt_status = `AQSTC_QS_TRIG;
          else if (!is_cs && !is_sw && !sss_ff)
            nxt_status = `AQSTC_QS_IDLE;
        end
        `AQSTC_QS_TRIG: begin
          if (edge_evt)
            nxt_trigger_overrun_flag = 1'b1;
          // gate closing mid-transfer waits for done
          if (is_level && !gate_open && !gate_pend_ff) begin
            if (!inflight_ff || cmd_done_i) begin
              nxt_status = is_cs ? `AQSTC_QS_WAIT : `AQSTC_QS_IDLE;
              nxt_pf     = 1'b1;
              if (!is_cs)
                nxt_sss = 1'b0;
            end else begin
              nxt_gate_pend = 1'b1;
            end
          end else if (gate_pend_ff && gate_open && !cmd_done_i) begin
            nxt_gate_pend = 1'b0;
            nxt_trigger_overrun_flag      = 1'b1;
          end else if (gate_pend_ff && cmd_done_i) begin
            nxt_gate_pend = 1'b0;
            nxt_pf        = 1'b1;
            nxt_status    = is_cs ? `AQSTC_QS_WAIT : `AQSTC_QS_IDLE;
            if (!is_cs)
              nxt_sss = 1'b0;
          end else if (cmd_done_i && inflight_ff && cmd_eoq_i) begin
            if (!is_cs) begin
              nxt_sss    = 1'b0;
              nxt_status = `AQSTC_QS_IDLE;
            end else if (is_edge) begin
              nxt_status = `AQSTC_QS_WAIT;
            end
          end else if (cmd_done_i && inflight_ff && cmd_pause_i && is_edge) begin
            // software and level modes never look at the pause bit
            nxt_status = `AQSTC_QS_WAIT;
            nxt_pf     = 1'b1;
          end
        end
        default: nxt_status = `AQSTC_QS_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // read data

  // unmapped or idle reads return zero
  always @* begin
    nxt_rdata = 32'h00000000;
    if (rd_i) begin
      case (addr_i)
        `AQSTC_OFF_CTRL: begin
          nxt_rdata[`AQSTC_CTRL_MODE_MSB:`AQSTC_CTRL_MODE_LSB] = mode_ff;
          nxt_rdata[`AQSTC_CTRL_FE_BIT] = fill_en_ff;
        end
        `AQSTC_OFF_STAT: begin
          nxt_rdata[`AQSTC_STAT_QS_MSB:`AQSTC_STAT_QS_LSB] = status_ff;
          nxt_rdata[`AQSTC_STAT_SSS_BIT]  = sss_ff;
          nxt_rdata[`AQSTC_STAT_PF_BIT]   = pf_ff;
          nxt_rdata[`AQSTC_STAT_TRIGGER_OVERRUN_FLAG_BIT] = trigger_overrun_flag_ff;
          nxt_rdata[`AQSTC_STAT_EOQF_BIT] = eoqf_ff;
          nxt_rdata[`AQSTC_STAT_FF_BIT]   = fill_flag_i;
        end
        `AQSTC_OFF_TCNT: nxt_rdata[TCW-1:0] = tc_ff;
        default:         nxt_rdata = 32'h00000000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // registers

  always @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      mode_ff      <= `AQSTC_MODE_DISABLED;
      status_ff    <= `AQSTC_QS_IDLE;
      sss_ff       <= 1'b0;
      pf_ff        <= 1'b0;
      trigger_overrun_flag_ff      <= 1'b0;
      eoqf_ff      <= 1'b0;
      tc_ff        <= `AQSTC_RST_TCNT;
      fill_en_ff   <= 1'b0;
      inflight_ff  <= 1'b0;
      ext_ff       <= 1'b0;
      dis_pend_ff  <= 1'b0;
      gate_pend_ff <= 1'b0;
      xfer_en_ff   <= 1'b0;
      abort_ff     <= 1'b0;
      inval_ff     <= 1'b0;
      fill_req_ff  <= 1'b0;
      rdata_o      <= 32'h00000000;
    end else begin
      mode_ff      <= nxt_mode;
      status_ff    <= nxt_status;
      sss_ff       <= nxt_sss;
      pf_ff        <= nxt_pf;
      trigger_overrun_flag_ff      <= nxt_trigger_overrun_flag;
      eoqf_ff      <= nxt_eoqf;
      tc_ff        <= nxt_tc;
      fill_en_ff   <= nxt_fill_en;
      inflight_ff  <= nxt_inflight;
      ext_ff       <= nxt_ext;
      dis_pend_ff  <= nxt_dis_pend;
      gate_pend_ff <= nxt_gate_pend;
      // no new transfers once a stop is pending
      xfer_en_ff   <= (nxt_status == `AQSTC_QS_TRIG) & ~nxt_dis_pend &
                      ~nxt_gate_pend & (nxt_mode != `AQSTC_MODE_DISABLED);
      // pulses last one cycle; levels hold
      abort_ff     <= nxt_abort;
      inval_ff     <= nxt_inval;
      fill_req_ff  <= fill_flag_i & nxt_fill_en;
      rdata_o      <= nxt_rdata;
    end
  end

  // outputs straight from the flops
  assign queue_status_o       = status_ff;
  assign single_scan_status_o = sss_ff;
  assign xfer_enable_o        = xfer_en_ff;
  assign abort_o              = abort_ff;
  assign invalidate_o         = inval_ff;
  assign fill_req_o           = fill_req_ff;

endmodule

/* hdl/aqstc_defs.vh */
// constants for the queue scan and trigger controller
`ifndef AQSTC_DEFS_VH
`define AQSTC_DEFS_VH

// register offsets (byte addresses)
`define AQSTC_OFF_CTRL     8'h00
`define AQSTC_OFF_STAT     8'h04
`define AQSTC_OFF_TCNT     8'h08

// control register fields
`define AQSTC_CTRL_MODE_LSB 0
`define AQSTC_CTRL_MODE_MSB 3
`define AQSTC_CTRL_SSE_BIT  4
`define AQSTC_CTRL_INV_BIT  5
`define AQSTC_CTRL_FE_BIT   6

// status register fields
`define AQSTC_STAT_QS_LSB   0
`define AQSTC_STAT_QS_MSB   1
`define AQSTC_STAT_SSS_BIT  2
`define AQSTC_STAT_PF_BIT   3
`define AQSTC_STAT_TRIGGER_OVERRUN_FLAG_BIT 4
`define AQSTC_STAT_EOQF_BIT 5
`define AQSTC_STAT_FF_BIT   6

// queue operating modes
`define AQSTC_MODE_DISABLED 4'h0
`define AQSTC_MODE_SS_SW    4'h1
`define AQSTC_MODE_SS_RISE  4'h2
`define AQSTC_MODE_SS_FALL  4'h3
`define AQSTC_MODE_SS_BOTH  4'h4
`define AQSTC_MODE_SS_HIGH  4'h5
`define AQSTC_MODE_SS_LOW   4'h6
`define AQSTC_MODE_CS_SW    4'h9
`define AQSTC_MODE_CS_RISE  4'hA
`define AQSTC_MODE_CS_FALL  4'hB
`define AQSTC_MODE_CS_BOTH  4'hC
`define AQSTC_MODE_CS_HIGH  4'hD
`define AQSTC_MODE_CS_LOW   4'hE
// bit 3 of the mode marks continuous scan, bits 2:0 the trigger kind
`define AQSTC_MODE_CS_BIT   3
`define AQSTC_KIND_SW       3'h1
`define AQSTC_KIND_RISE     3'h2
`define AQSTC_KIND_FALL     3'h3
`define AQSTC_KIND_BOTH     3'h4
`define AQSTC_KIND_HIGH     3'h5
`define AQSTC_KIND_LOW      3'h6

// queue status encodings
`define AQSTC_QS_IDLE       2'h0
`define AQSTC_QS_WAIT       2'h2
`define AQSTC_QS_TRIG       2'h3

// reset values
`define AQSTC_RST_TCNT      11'h000

`endif

/* hdl/aqstc_trig_detect.v */
// edge and level trigger detection for one command queue
`timescale 1ns/100ps
`include "aqstc_defs.vh"

module aqstc_trig_detect (
  input  wire       ref_clk_i,
  input  wire       arst_n_i,
  input  wire       trig_i,
  input  wire       det_en_i,
  input  wire [2:0] kind_i,
  output wire       edge_o,
  output wire       gate_open_o
);

  reg prev_ff;
  reg armed_ff;

  // previous level always tracks; armed only after a cycle of enable
  always @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      prev_ff  <= 1'b0;
      armed_ff <= 1'b0;
    end else begin
      prev_ff  <= trig_i;
      armed_ff <= det_en_i;
    end
  end

  wire rise = trig_i & ~prev_ff;
  wire fall = ~trig_i & prev_ff;

  // a disarmed detector forgets history: only a fresh edge counts
  assign edge_o = det_en_i & armed_ff &
                  (((kind_i == `AQSTC_KIND_RISE) & rise) |
                   ((kind_i == `AQSTC_KIND_FALL) & fall) |
                   ((kind_i == `AQSTC_KIND_BOTH) & (rise | fall)));

  assign gate_open_o = det_en_i &
                       (((kind_i == `AQSTC_KIND_HIGH) & trig_i) |
                        ((kind_i == `AQSTC_KIND_LOW) & ~trig_i));

endmodule

/* tb/aqstc_xfer_model.sv */
// transfer link model standing in for the command prioritizer
`timescale 1ns/100ps
module aqstc_xfer_model (
  input  logic ref_clk_i,
  input  logic xfer_enable_i,
  output logic start_o,
  output logic ext_o,
  output logic done_o,
  output logic eoq_o,
  output logic pause_o,
  output logic bit26_o
);
  initial {start_o, ext_o, done_o, eoq_o, pause_o, bit26_o} = 6'h00;
  // start only while forwarding is allowed; b marks bit 26 already shifted
  task start(input e, input b, output ok);
    integer i;
    begin
      ok = 0;
      for (i = 0; i < 20 && !ok; i++) begin
        @(posedge ref_clk_i);
        ok = xfer_enable_i;
      end
      if (ok) begin
        start_o <= 1'h1;
        ext_o <= e;
        @(posedge ref_clk_i);
        start_o <= 1'h0;
        ext_o <= ~e;
        bit26_o <= b;
      end
    end
  endtask
  // completion with the command's end and pause bits
  task finish(input q, input p);
    begin
      @(posedge ref_clk_i);
      done_o <= 1'h1;
      eoq_o <= q;
      pause_o <= p;
      @(posedge ref_clk_i);
      done_o <= 1'h0;
      eoq_o <= ~q;
      pause_o <= ~p;
      bit26_o <= 1'h0;
    end
  endtask
endmodule

/* tb/aqstc_ctrl_checker.sv */
// assertions on the ports of the queue controller
`timescale 1ns/100ps
module aqstc_ctrl_checker #(
  parameter TCW = 11
) (
  input logic        ref_clk_i,
  input logic        arst_n_i,
  input logic [7:0]  addr_i,
  input logic [31:0] wdata_i,
  input logic        wr_i,
  input logic        trig_i,
  input logic        cmd_start_i,
  input logic        cmd_ext_i,
  input logic        cmd_done_i,
  input logic        cmd_eoq_i,
  input logic        cmd_pause_i,
  input logic        ser_bit26_i,
  input logic        fill_flag_i,
  input logic [1:0]  queue_status_o,
  input logic        single_scan_status_o,
  input logic        xfer_enable_o,
  input logic        abort_o,
  input logic        invalidate_o,
  input logic        fill_req_o
);
  logic       busy_ff, ext_ff, fe_ff;
  logic [3:0] mode_ff;
  wire        ctrl_wr = wr_i && addr_i == 8'h00;
  wire        dis_wr  = ctrl_wr && wdata_i[3:0] == 4'h0;
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      {busy_ff, ext_ff, fe_ff} <= 3'h0;
      mode_ff <= 4'h0;
    end else begin
      busy_ff <= cmd_start_i || (busy_ff && !cmd_done_i && !abort_o);
      ext_ff <= cmd_start_i ? cmd_ext_i : ext_ff;
      fe_ff <= ctrl_wr ? wdata_i[6] : fe_ff;
      if (dis_wr)
        mode_ff <= 4'h0;
      else if (ctrl_wr && mode_ff == 4'h0 && queue_status_o == 2'h0)
        mode_ff <= wdata_i[3:0];
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!arst_n_i);
  disabled_quiet_a:
  assert property (mode_ff == 4'h0 && !busy_ff |-> queue_status_o == 2'h0 && !xfer_enable_o
    && !single_scan_status_o) else $error("disabled queue not idle");
  serial_abort_a:
  assert property (dis_wr && busy_ff && ext_ff && !ser_bit26_i && !cmd_done_i
    |=> abort_o && queue_status_o == 2'h0) else $error("serial transfer not aborted");
  invalidate_pulse_a:
  assert property (invalidate_o == $past(ctrl_wr && wdata_i[5])) else $error("invalidate pulse");
  fill_follow_a:
  assert property (fill_req_o == $past(fill_flag_i && (ctrl_wr ? wdata_i[6] : fe_ff)))
    else $error("fill request");
  eoq_stops_a:
  assert property (cmd_done_i && cmd_eoq_i && busy_ff && !mode_ff[3] && mode_ff != 4'h0
    && !ctrl_wr |=> !single_scan_status_o && !xfer_enable_o) else $error("end of queue kept on");
  pause_edge_a:
  assert property (cmd_done_i && cmd_pause_i && !cmd_eoq_i && busy_ff && mode_ff inside {[2:4]}
    && !ctrl_wr |=> single_scan_status_o && !xfer_enable_o) else $error("edge pause");
  unarmed_ignore_a:
  assert property (mode_ff inside {[2:6]} && !single_scan_status_o && !busy_ff
    |-> queue_status_o != 2'h3) else $error("triggered without single scan status");
  gate_open_trig_a:
  assert property ((mode_ff == 4'h5 && single_scan_status_o && trig_i) [*5]
    |-> queue_status_o == 2'h3) else $error("open gate not triggered");
endmodule
bind aqstc_ctrl aqstc_ctrl_checker #(.TCW(TCW)) aqstc_ctrl_checker_inst (.ref_clk_i, .arst_n_i,
  .addr_i, .wdata_i, .wr_i, .trig_i, .cmd_start_i, .cmd_ext_i, .cmd_done_i, .cmd_eoq_i,
  .cmd_pause_i, .ser_bit26_i, .fill_flag_i, .queue_status_o, .single_scan_status_o,
  .xfer_enable_o, .abort_o, .invalidate_o, .fill_req_o);

/* tb/test_adc_queue_scan_trigger_ctrl.sv */
// self-checking bench for the queue scan and trigger controller
`timescale 1ns/100ps
`define CHK(n, e, v) begin n_checks++; if ((v) !== (e)) begin failures++; \
  $display("unexpected %s exp %h got %h", n, e, v); end end
module test_adc_queue_scan_trigger_ctrl;
  reg         ref_clk_i = 0, arst_n_i = 0, wr_i = 0, rd_i = 0, trig_i = 0, fill_flag_i = 0;
  reg  [7:0]  addr_i = 8'h00;
  reg  [31:0] wdata_i = 32'h0, d;
  wire [31:0] rdata_o;
  wire [1:0]  qs;
  wire        single_scan_status, xen, ab, inv, frq, c_st, c_ex, c_dn, c_eq, c_pa, c_26;
  integer     failures = 0, n_checks = 0, i;
  reg         ok;
  always #10 ref_clk_i = ~ref_clk_i;
  aqstc_ctrl aqstc_ctrl_inst (.ref_clk_i, .arst_n_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
    .trig_i, .cmd_start_i(c_st), .cmd_ext_i(c_ex), .cmd_done_i(c_dn), .cmd_eoq_i(c_eq),
    .cmd_pause_i(c_pa), .ser_bit26_i(c_26), .fill_flag_i, .queue_status_o(qs),
    .single_scan_status_o(single_scan_status), .xfer_enable_o(xen), .abort_o(ab), .invalidate_o(inv),
    .fill_req_o(frq));
  aqstc_xfer_model aqstc_xfer_model_inst (.ref_clk_i, .xfer_enable_i(xen), .start_o(c_st),
    .ext_o(c_ex), .done_o(c_dn), .eoq_o(c_eq), .pause_o(c_pa), .bit26_o(c_26));
  ////////////////////////////////////////////////////////////////////////////////
  task finish_test;
    begin
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask
  task w(input [7:0] a, input [31:0] v);
    begin
      @(posedge ref_clk_i);
      wr_i <= 1'h1;
      addr_i <= a;
      wdata_i <= v;
      @(posedge ref_clk_i);
      wr_i <= 1'h0;
      @(negedge ref_clk_i);
    end
  endtask
  task r(input [7:0] a);
    begin
      @(posedge ref_clk_i);
      rd_i <= 1'h1;
      addr_i <= a;
      @(posedge ref_clk_i);
      rd_i <= 1'h0;
      @(negedge ref_clk_i);
      d = rdata_o;
    end
  endtask
  task wq(input [1:0] s);
    begin
      for (i = 0; i < 30 && qs !== s; i++) @(negedge ref_clk_i);
      `CHK("status", s, qs)
      if (qs !== s) finish_test;
    end
  endtask
  task tg(input v);
    begin
      @(posedge ref_clk_i);
      trig_i <= v;
      repeat (4) @(negedge ref_clk_i);
    end
  endtask
  task go(input e, input b);
    begin
      aqstc_xfer_model_inst.start(e, b, ok);
      `CHK("start", 1'h1, ok)
      if (!ok) finish_test;
    end
  endtask
  task fin(input q, input p);
    begin
      aqstc_xfer_model_inst.finish(q, p);
      @(negedge ref_clk_i);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge ref_clk_i);
    arst_n_i <= 1'h1;
    r(8'h08); `CHK("tcnt", 32'h0, d)
    w(8'h00, 32'h11); wq(2'h3); `CHK("sss", 1'h1, single_scan_status)
    w(8'h00, 32'h12); r(8'h00); `CHK("mode", 4'h1, d[3:0])
    r(8'h04); `CHK("overrun", 1'h0, d[4])
    go(0, 0); fin(0, 1); `CHK("xen", 1'h1, xen)
    go(0, 0); fin(1, 0); `CHK("sss", 1'h0, single_scan_status)
    r(8'h08); `CHK("tcnt", 32'h2, d)
    w(8'h00, 32'h11); wq(2'h3);
    w(8'h00, 32'h00); `CHK("status", 2'h0, qs)
    r(8'h08); `CHK("tcnt", 32'h2, d)
    w(8'h08, 32'h0); r(8'h08); `CHK("tcnt", 32'h0, d)
    w(8'h00, 32'h20); `CHK("inv", 1'h1, inv)
    $display("end of software scan test");
    tg(1); w(8'h00, 32'h12); `CHK("sss", 1'h1, single_scan_status)
    wq(2'h2); tg(0); `CHK("status", 2'h2, qs)
    tg(1); wq(2'h3); tg(0); tg(1);
    r(8'h04); `CHK("overrun", 1'h1, d[4])
    w(8'h04, 32'h10);
    go(0, 0); fin(0, 1); `CHK("sss", 1'h1, single_scan_status)
    `CHK("xen", 1'h0, xen)
    tg(0); tg(1); wq(2'h3);
    go(0, 0); fin(1, 0); `CHK("sss", 1'h0, single_scan_status)
    tg(0); tg(1); `CHK("unarmed", 1'h0, qs === 2'h3)
    w(8'h00, 32'h12); tg(0); tg(1); wq(2'h3);
    go(0, 0); w(8'h00, 32'h00); `CHK("status", 2'h3, qs)
    fin(0, 0); `CHK("status", 2'h0, qs)
    w(8'h00, 32'h11); wq(2'h3);
    go(1, 1); w(8'h00, 32'h00); `CHK("abort", 1'h0, ab)
    fin(0, 0); `CHK("status", 2'h0, qs)
    w(8'h00, 32'h11); wq(2'h3);
    go(1, 0); w(8'h00, 32'h00); `CHK("abort", 1'h1, ab)
    r(8'h08); `CHK("tcnt", 32'h4, d)
    $display("end of edge and disable test");
    w(8'h00, 32'h15); wq(2'h3);
    tg(0); `CHK("sss", 1'h0, single_scan_status)
    r(8'h04); `CHK("pause", 1'h1, d[3])
    w(8'h04, 32'h18); tg(1); w(8'h00, 32'h15); wq(2'h3);
    go(1, 0); tg(0); tg(1); fin(0, 0); `CHK("status", 2'h3, qs)
    r(8'h04); `CHK("flags", 2'h2, d[4:3])
    w(8'h00, 32'h00); tg(0); w(8'h00, 32'h16); wq(2'h3);
    $display("end of level test");
    @(posedge ref_clk_i);
    fill_flag_i <= 1'h1;
    w(8'h00, 32'h40); @(negedge ref_clk_i); `CHK("fill", 1'h1, frq)
    w(8'h00, 32'h00); @(negedge ref_clk_i); `CHK("fill", 1'h0, frq)
    $display("end of fill test");
    finish_test;
  end
endmodule
